// >>> src/halt_pkg.sv
// shared constants, types and register map of the halt release controller
package halt_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses, one word each)
    // -------------------------------------------------------------
    localparam logic [3:0] ADDR_STANDBY_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MODE_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int HALT_REQ_BIT = 0;
    localparam int LVL3_SEL_BIT = 0;
    localparam int STAT_HALTED_BIT = 0;
    localparam int STAT_PEND_NMI_BIT = 1;
    localparam int STAT_PEND_MASK_BIT = 2;
    localparam int STAT_LAST_DEC_LSB = 4;
    localparam logic LVL3_SEL_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] LEVEL3 = 2'h3;
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        DEC_NONE,
        DEC_RESET,
        DEC_VECTOR,
        DEC_RESUME,
        DEC_MACRO
    } decision_t;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALTED,
        ST_MACRO
    } halt_state_t;
    typedef struct packed {
        logic nmi_pin;
        logic wdt_nmi;
        logic mask_req;
        logic mask_flag;
        logic macro_req;
        logic macro_mask;
    } wake_req_t;
    typedef struct packed {
        logic int_enable;
        logic svc_active;
        logic [1:0] svc_prio;
        logic [1:0] req_prio;
        logic nmi_svc_active;
        logic nmi_svc_blocks;
    } wake_ctx_t;
endpackage : halt_pkg

// >>> src/halt_wake_decide.sv
// combinational wake decision for one halted cycle
`timescale 1ns/100ps
module halt_wake_decide (
    // request side
    input wire logic reset_req_i,
    input wire halt_pkg::wake_req_t req_i,
    input wire halt_pkg::wake_ctx_t ctx_i,
    input wire logic lvl3_sel_i,
    // outcome
    output halt_pkg::decision_t dec_o,
    output logic mask_accept_o,
    output logic nmi_accept_o
);
    import halt_pkg::*;

    always_comb begin
        mask_accept_o = ctx_i.int_enable && (!ctx_i.svc_active
            || (ctx_i.svc_prio > ctx_i.req_prio)
            || (ctx_i.svc_prio == LEVEL3 && !lvl3_sel_i));
        nmi_accept_o = !ctx_i.nmi_svc_active || !ctx_i.nmi_svc_blocks;
        dec_o = DEC_NONE;
        // reset, pin nmi, unmasked requests only
        if (reset_req_i) begin
            dec_o = DEC_RESET;
        end else if (req_i.nmi_pin) begin
            dec_o = nmi_accept_o ? DEC_VECTOR : DEC_RESUME;
        end else if (req_i.macro_req && !req_i.macro_mask) begin
            dec_o = DEC_MACRO;
        end else if (req_i.mask_req && !req_i.mask_flag) begin
            dec_o = mask_accept_o ? DEC_VECTOR : DEC_RESUME;
        end
        // watchdog nmi is deliberately never looked at here
    end
endmodule : halt_wake_decide

// >>> src/halt_release_ctrl.sv
// halt mode entry and release controller with an axi4-lite register slave
`timescale 1ns/100ps
module halt_release_ctrl (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // interrupt controller side
    input wire logic reset_req_i,
    input wire halt_pkg::wake_req_t wake_req_i,
    input wire halt_pkg::wake_ctx_t wake_ctx_i,
    input wire logic core_can_accept_i,
    input wire logic macro_done_i,
    input wire logic macro_end_i,
    input wire logic vector_on_transfer_end_bit_i,
    // sequencer side
    output logic cpu_halted_o,
    output logic vector_nmi_o,
    output logic vector_mask_o,
    output logic resume_o,
    output logic reset_seq_o,
    output logic ram_retain_o,
    output logic macro_start_o,
    output logic pend_nmi_o,
    output logic pend_mask_o
);
    import halt_pkg::*;

    // -------------------------------------------------------------
    // register bus
    // -------------------------------------------------------------
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic level3_priority_select_r, lvl3_sel_nxt;
    logic halt_write;
    logic [31:0] status_word;

    halt_state_t state_r, state_nxt;
    decision_t dec, last_dec_r, last_dec_nxt;
    logic pend_nmi_nxt, pend_mask_nxt, halted_nxt;
    logic vec_nmi_nxt, vec_mask_nxt, resume_nxt, rst_seq_nxt, macro_nxt;
    logic mask_accept, nmi_accept;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_HALTED_BIT] = cpu_halted_o;
        status_word[STAT_PEND_NMI_BIT] = pend_nmi_o;
        status_word[STAT_PEND_MASK_BIT] = pend_mask_o;
        status_word[STAT_LAST_DEC_LSB +: 3] = last_dec_r;
    end

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = s_axi_bvalid_o;
        bresp_nxt = s_axi_bresp_o;
        rvalid_nxt = s_axi_rvalid_o;
        rresp_nxt = s_axi_rresp_o;
        rdata_nxt = s_axi_rdata_o;
        lvl3_sel_nxt = level3_priority_select_r;
        halt_write = 1'b0;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_i;
            wstrb0_nxt = s_axi_wstrb_i[0];
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;
        end
        // commit once both halves are in and no response is outstanding
        if (aw_got_r && w_got_r && !s_axi_bvalid_o) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            case (awaddr_r)
                ADDR_STANDBY_CTRL: begin
                    halt_write = wstrb0_r && wdata_r[HALT_REQ_BIT];
                end
                ADDR_MODE_CTRL: begin
                    if (wstrb0_r) begin
                        lvl3_sel_nxt = wdata_r[LVL3_SEL_BIT];
                    end
                end
                ADDR_STATUS: begin
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr_i)
                ADDR_STANDBY_CTRL: rdata_nxt = {31'h0000_0000, cpu_halted_o};
                ADDR_MODE_CTRL: rdata_nxt = {31'h0000_0000, level3_priority_select_r};
                ADDR_STATUS: rdata_nxt = status_word;
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        awready_nxt = !aw_got_nxt;
        wready_nxt = !w_got_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
            level3_priority_select_r <= LVL3_SEL_RESET;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb0_r <= wstrb0_nxt;
            s_axi_awready_o <= awready_nxt;
            s_axi_wready_o <= wready_nxt;
            s_axi_bvalid_o <= bvalid_nxt;
            s_axi_bresp_o <= bresp_nxt;
            s_axi_arready_o <= arready_nxt;
            s_axi_rvalid_o <= rvalid_nxt;
            s_axi_rresp_o <= rresp_nxt;
            s_axi_rdata_o <= rdata_nxt;
            level3_priority_select_r <= lvl3_sel_nxt;
        end
    end

    // -------------------------------------------------------------
    // wake decision and halt sequencing
    // -------------------------------------------------------------
    halt_wake_decide u_decide (
        .reset_req_i(reset_req_i),
        .req_i(wake_req_i),
        .ctx_i(wake_ctx_i),
        .lvl3_sel_i(level3_priority_select_r),
        .dec_o(dec),
        .mask_accept_o(mask_accept),
        .nmi_accept_o(nmi_accept)
    );

    always_comb begin
        state_nxt = state_r;
        last_dec_nxt = last_dec_r;
        pend_nmi_nxt = pend_nmi_o;
        pend_mask_nxt = pend_mask_o;
        vec_nmi_nxt = 1'b0;
        vec_mask_nxt = 1'b0;
        resume_nxt = 1'b0;
        rst_seq_nxt = 1'b0;
        macro_nxt = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (core_can_accept_i && pend_nmi_o) begin
                    pend_nmi_nxt = 1'b0;
                    vec_nmi_nxt = 1'b1;
                end else if (core_can_accept_i && pend_mask_o) begin
                    pend_mask_nxt = 1'b0;
                    vec_mask_nxt = 1'b1;
                end
                if (halt_write) begin
                    state_nxt = ST_HALTED;
                end
            end
            ST_HALTED: begin
                last_dec_nxt = dec;
                case (dec)
                    DEC_RESET: begin
                        state_nxt = ST_RUN;
                        rst_seq_nxt = 1'b1;
                    end
                    DEC_VECTOR: begin
                        state_nxt = ST_RUN;
                        vec_nmi_nxt = wake_req_i.nmi_pin;
                        vec_mask_nxt = !wake_req_i.nmi_pin;
                    end
                    DEC_RESUME: begin
                        state_nxt = ST_RUN;
                        resume_nxt = 1'b1;
                        pend_nmi_nxt = pend_nmi_o || wake_req_i.nmi_pin;
                        pend_mask_nxt = pend_mask_o || !wake_req_i.nmi_pin;
                    end
                    DEC_MACRO: begin
                        state_nxt = ST_MACRO;
                        macro_nxt = 1'b1;
                    end
                    default: begin
                        state_nxt = ST_HALTED;
                    end
                endcase
            end
            ST_MACRO: begin
                if (reset_req_i) begin
                    state_nxt = ST_RUN;
                    rst_seq_nxt = 1'b1;
                end else if (macro_done_i) begin
                    if (!macro_end_i || vector_on_transfer_end_bit_i) begin
                        state_nxt = ST_HALTED;
                    end else if (mask_accept) begin
                        state_nxt = ST_RUN;
                        vec_mask_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_RUN;
                        resume_nxt = 1'b1;
                        pend_mask_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        halted_nxt = (state_nxt != ST_RUN);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_RUN;
            last_dec_r <= DEC_NONE;
            cpu_halted_o <= 1'b0;
            pend_nmi_o <= 1'b0;
            pend_mask_o <= 1'b0;
            vector_nmi_o <= 1'b0;
            vector_mask_o <= 1'b0;
            resume_o <= 1'b0;
            reset_seq_o <= 1'b0;
            macro_start_o <= 1'b0;
            ram_retain_o <= 1'b1;
        end else begin
            state_r <= state_nxt;
            last_dec_r <= last_dec_nxt;
            cpu_halted_o <= halted_nxt;
            pend_nmi_o <= pend_nmi_nxt;
            pend_mask_o <= pend_mask_nxt;
            vector_nmi_o <= vec_nmi_nxt;
            vector_mask_o <= vec_mask_nxt;
            resume_o <= resume_nxt;
            reset_seq_o <= rst_seq_nxt;
            macro_start_o <= macro_nxt;
            ram_retain_o <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_halt_entry: assert property (halt_write && state_r == ST_RUN |=> cpu_halted_o)
        else $error("halt write did not halt");
    a_wake_sources: assert property ($fell(cpu_halted_o) |-> $past(reset_req_i)
        || $past(wake_req_i.nmi_pin) || $past(wake_req_i.mask_req) || $past(macro_done_i))
        else $error("halt left without a wake source");
    a_wdt_no_wake: assert property (state_r == ST_HALTED && wake_req_i.wdt_nmi
        && !reset_req_i && !wake_req_i.nmi_pin && !wake_req_i.mask_req
        && !wake_req_i.macro_req |=> cpu_halted_o)
        else $error("watchdog nmi released halt");
    a_reset_wake: assert property (state_r == ST_HALTED && reset_req_i
        |=> reset_seq_o && !cpu_halted_o)
        else $error("reset did not end halt");
    a_ram_kept: assert property (reset_seq_o |-> ram_retain_o)
        else $error("ram not retained on reset from halt");
    a_nmi_vector: assert property (state_r == ST_HALTED && !reset_req_i
        && wake_req_i.nmi_pin && nmi_accept |=> vector_nmi_o && $stable(pend_nmi_o))
        else $error("accepted nmi did not vector");
    a_nmi_pending: assert property (state_r == ST_HALTED && !reset_req_i
        && wake_req_i.nmi_pin && !nmi_accept |=> resume_o && pend_nmi_o)
        else $error("blocked nmi not held pending");
    a_pend_taken: assert property (state_r == ST_RUN && pend_nmi_o && core_can_accept_i
        |=> vector_nmi_o ##1 !vector_nmi_o)
        else $error("pending nmi not taken");
    a_mask_hold: assert property (state_r == ST_HALTED && !reset_req_i
        && !wake_req_i.nmi_pin && !wake_req_i.macro_req && wake_req_i.mask_req
        && wake_req_i.mask_flag |=> cpu_halted_o)
        else $error("masked request released halt");
    a_macro_rehalt: assert property (state_r == ST_MACRO && !reset_req_i && macro_done_i
        && !macro_end_i |=> state_r == ST_HALTED && !resume_o)
        else $error("macro service did not re-halt");
    a_enable_clear: assert property (state_r == ST_HALTED && !reset_req_i
        && !wake_req_i.nmi_pin && !(wake_req_i.macro_req && !wake_req_i.macro_mask)
        && wake_req_i.mask_req && !wake_req_i.mask_flag && !wake_ctx_i.int_enable
        |=> resume_o && !vector_mask_o)
        else $error("disabled wake vectored");

    c_nmi_wake: cover property (state_r == ST_HALTED ##1 vector_nmi_o);
    c_pending_resume: cover property (resume_o && pend_mask_o);
    c_macro_cycle: cover property (macro_start_o ##[1:20] state_r == ST_HALTED);
    c_reset_wake: cover property (cpu_halted_o ##1 reset_seq_o);
endmodule : halt_release_ctrl

// >>> sim/macro_engine_model.sv
// behavioural model of the macro transfer engine beside the halt controller
`timescale 1ns/100ps
module macro_engine_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // transfer request and setup
    input wire logic macro_start_i,
    input wire logic end_cfg_i,
    input wire logic vec_cfg_i,
    input wire logic [3:0] delay_i,
    // transfer outcome
    output logic macro_done_o,
    output logic macro_end_o,
    output logic vector_bit_o
);
    // ------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------
    logic busy;
    logic [3:0] wait_cnt;
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy <= 1'h0;
            wait_cnt <= 4'h0;
            macro_done_o <= 1'h0;
            macro_end_o <= 1'h0;
            vector_bit_o <= 1'h0;
        end else begin
            macro_done_o <= 1'h0;
            // flags mean nothing without done, so show the wrong value there
            macro_end_o <= ~end_cfg_i;
            vector_bit_o <= ~vec_cfg_i;
            if (macro_start_i && !busy) begin
                busy <= 1'h1;
                wait_cnt <= delay_i;
            end else if (busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'h0;
                macro_done_o <= 1'h1;
                macro_end_o <= end_cfg_i;
                vector_bit_o <= vec_cfg_i;
            end
        end
    end
endmodule : macro_engine_model

// >>> sim/tb_halt_release_ctrl.sv
// self-checking testbench of the halt release controller
`timescale 1ns/100ps
module tb_halt_release_ctrl;
    import halt_pkg::*;
    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    typedef struct packed {
        logic rst;
        wake_req_t rq;
        wake_ctx_t cx;
        logic sel3;
        logic [4:0] out;
        logic [1:0] pend;
    } case_t;
    logic clk_sys_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, delay = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic reset_req = 1'h0, can_acc = 1'h0, end_cfg = 1'h0, vec_cfg = 1'h0;
    wake_req_t wake_req = '0;
    wake_ctx_t wake_ctx = '0;
    logic awready, wready, bvalid, arready, rvalid, m_done, m_end, v_bit;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic halted, vnmi, vmask, resume, rseq, retain, mstart, pnmi, pmask;
    wire logic [4:0] pulses = {rseq, vnmi, vmask, resume, mstart};
    logic [4:0] exp_q[$];
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'h92897A8E;
    case_t cs[12];
    always #25 clk_sys_i = ~clk_sys_i;
    halt_release_ctrl halt_release_ctrl_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .reset_req_i(reset_req),
        .wake_req_i(wake_req), .wake_ctx_i(wake_ctx), .core_can_accept_i(can_acc),
        .macro_done_i(m_done), .macro_end_i(m_end), .vector_on_transfer_end_bit_i(v_bit),
        .cpu_halted_o(halted), .vector_nmi_o(vnmi), .vector_mask_o(vmask),
        .resume_o(resume), .reset_seq_o(rseq), .ram_retain_o(retain),
        .macro_start_o(mstart), .pend_nmi_o(pnmi), .pend_mask_o(pmask)
    );
    macro_engine_model macro_engine_model_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .macro_start_i(mstart),
        .end_cfg_i(end_cfg), .vec_cfg_i(vec_cfg), .delay_i(delay),
        .macro_done_o(m_done), .macro_end_o(m_end), .vector_bit_o(v_bit)
    );
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic case_t mk(logic r, logic [5:0] q, logic [7:0] x, logic p,
                                 logic [4:0] o, logic [1:0] d);
        mk = {r, q, x, p, o, d};
    endfunction : mk
    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    // one transfer, valids held until each own ready edge
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic [1:0] er);
        int t;
        logic ga, gw;
        @(posedge clk_sys_i);
        ga = 1'h0;
        gw = !wr;
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
        end else begin
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
        end
        for (t = 0; t < 50; t++) begin
            @(posedge clk_sys_i);
            if (wr && bvalid === 1'h1 && ga && gw) break;
            if (!wr && rvalid === 1'h1 && ga) break;
            if (wr && awvalid && awready === 1'h1) begin
                ga = 1'h1;
                awvalid <= 1'h0;
            end
            if (wr && wvalid && wready === 1'h1) begin
                gw = 1'h1;
                wvalid <= 1'h0;
            end
            if (!wr && arvalid && arready === 1'h1) begin
                ga = 1'h1;
                arvalid <= 1'h0;
            end
        end
        bready <= 1'h0;
        rready <= 1'h0;
        check(t < 50, 1'h1);
        check(wr ? bresp : rresp, er);
        if (!wr && er == RESP_OKAY) check(rdata, ed);
    endtask : axi
    // halt, apply one wake pattern, follow any pending request
    task automatic run_case(input case_t c);
        int t;
        axi(1'h1, ADDR_MODE_CTRL, {31'h0, c.sel3}, 32'h0, RESP_OKAY);
        axi(1'h1, ADDR_STANDBY_CTRL, 32'h1, 32'h0, RESP_OKAY);
        check(halted, 1'h1);
        axi(1'h0, ADDR_STANDBY_CTRL, 32'h0, 32'h1, RESP_OKAY);
        @(posedge clk_sys_i);
        reset_req <= c.rst;
        wake_req <= c.rq;
        wake_ctx <= c.cx;
        if (c.out != 5'h00) exp_q.push_back(c.out);
        else begin
            repeat (8) @(posedge clk_sys_i);
            check(halted, 1'h1);
            reset_req <= 1'h1;
            exp_q.push_back(5'h10);
        end
        for (t = 0; t < 2 && halted !== 1'h0; t++) @(negedge clk_sys_i);
        check(halted, 1'h0);
        @(posedge clk_sys_i);
        reset_req <= 1'h0;
        wake_req <= '0;
        wake_ctx <= '0;
        @(negedge clk_sys_i);
        check({pnmi, pmask}, c.pend);
        if (c.pend != 2'h0) begin
            @(posedge clk_sys_i);
            can_acc <= 1'h1;
            exp_q.push_back(c.pend[1] ? 5'h08 : 5'h04);
            for (t = 0; t < 4 && (pnmi | pmask) !== 1'h0; t++) @(negedge clk_sys_i);
            check(pnmi | pmask, 1'h0);
            @(posedge clk_sys_i);
            can_acc <= 1'h0;
        end
        repeat (3) @(posedge clk_sys_i);
        check(exp_q.size(), 0);
    endtask : run_case
    // ------------------------------------------------
    // outcome monitor and watchdog
    // ------------------------------------------------
    always @(negedge clk_sys_i) begin
        if (reset_n_i && pulses !== 5'h00) begin
            check(pulses, exp_q.size() != 0 ? exp_q.pop_front() : 5'h00);
        end
    end
    initial begin
        repeat (8000) @(posedge clk_sys_i);
        fail_count++;
        close_out();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        int i;
        int t;
        case_t c;
        cs[0] = mk(1'h0, 6'h20, 8'h00, 1'h0, 5'h08, 2'h0);
        cs[1] = mk(1'h0, 6'h20, 8'h02, 1'h0, 5'h08, 2'h0);
        cs[2] = mk(1'h0, 6'h20, 8'h03, 1'h0, 5'h02, 2'h2);
        cs[3] = mk(1'h0, 6'h08, 8'h80, 1'h1, 5'h04, 2'h0);
        cs[4] = mk(1'h0, 6'h08, 8'hF4, 1'h1, 5'h04, 2'h0);
        cs[5] = mk(1'h0, 6'h08, 8'hE8, 1'h1, 5'h02, 2'h1);
        cs[6] = mk(1'h0, 6'h08, 8'hFC, 1'h0, 5'h04, 2'h0);
        cs[7] = mk(1'h0, 6'h08, 8'hFC, 1'h1, 5'h02, 2'h1);
        cs[8] = mk(1'h0, 6'h08, 8'hD8, 1'h1, 5'h02, 2'h1);
        cs[9] = mk(1'h0, 6'h08, 8'h00, 1'h0, 5'h02, 2'h1);
        cs[10] = mk(1'h1, 6'h2A, 8'h80, 1'h0, 5'h10, 2'h0);
        cs[11] = mk(1'h0, 6'h1F, 8'h80, 1'h0, 5'h00, 2'h0);
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        check(retain, 1'h1);
        axi(1'h0, ADDR_MODE_CTRL, 32'h0, {31'h0, LVL3_SEL_RESET}, RESP_OKAY);
        axi(1'h1, ADDR_STATUS, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
        axi(1'h0, ADDR_STATUS, 32'h0, 32'h0, RESP_OKAY);
        axi(1'h1, 4'hC, 32'h1, 32'h0, RESP_SLVERR);
        axi(1'h0, 4'hC, 32'h0, 32'h0, RESP_SLVERR);
        for (i = 0; i < 12; i++) begin
            c = cs[i];
            if (i == 3) c.cx.req_prio = 2'($random(seed));
            run_case(c);
        end
        // last halted cycle of the final case decided a reset, nothing pending
        axi(1'h0, ADDR_STATUS, 32'h0, 32'(DEC_RESET) << STAT_LAST_DEC_LSB, RESP_OKAY);
        check(retain, 1'h1);
        // macro transfers: no end, end with vector bit set, end with it clear
        axi(1'h1, ADDR_STANDBY_CTRL, 32'h1, 32'h0, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys_i);
            end_cfg <= (i > 0);
            vec_cfg <= (i == 1);
            delay <= 4'($random(seed));
            wake_req <= 6'h02;
            wake_ctx <= 8'h80;
            exp_q.push_back(5'h01);
            if (i == 2) exp_q.push_back(5'h04);
            for (t = 0; t < 4 && mstart !== 1'h1; t++) @(negedge clk_sys_i);
            @(posedge clk_sys_i);
            wake_req <= '0;
            for (t = 0; t < 40 && m_done !== 1'h1; t++) @(negedge clk_sys_i);
            repeat (3) @(negedge clk_sys_i);
            check(halted, (i < 2) ? 1'h1 : 1'h0);
            check(exp_q.size(), 0);
        end
        close_out();
    end
endmodule : tb_halt_release_ctrl
